// ### logic/dbg_port_defines.svh
// How it works
// - Characters use one start bit, eight data bits LSB first, 1.5 stop bits.
// - After reset the port idles until the host's first character 80H.
// - The low time of start plus seven data bits sets the bit length.
// - Bit rates down to the core clock divided by 1023 are measured.
// - A 16-bit runtime counter counts core clocks once debug mode is left.
// - The runtime counter stops on debug entry and saturates at FFFFH.
// - A watchpoint hit enters debug mode and sets control bit 7.
// - Command codes 00H to 09H as listed; 01H is reserved.
// - Outside debug mode only 00H, 02H, 04H and 05H are executed.
// - Read protection disables 06H, 07H, 09H and restricts 08H and 04H.
// - Control write stores one byte; protected, the halt flag cannot clear.
// - Control read returns the control register byte.
// - Program counter write takes high then low; discarded if not allowed.
// - Program counter read returns high then low, or FFFFH if not allowed.
// - Register write: command, upper address, lower address, size, data; zero means 256.
// - Register writes dropped outside debug; protected, only flash control FF8H to FFFH passes, FF8H only with 63H.
// - Register read returns 1 to 256 bytes from the given address.
// - Debug pin low during stop mode requests a full system reset.
`ifndef DBG_PORT_DEFINES_SVH
`define DBG_PORT_DEFINES_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_REV_RD   8'h00
`define CMD_STAT_RD  8'h02
`define CMD_RUN_RD   8'h03
`define CMD_CTL_WR   8'h04
`define CMD_CTL_RD   8'h05
`define CMD_PC_WR    8'h06
`define CMD_PC_RD    8'h07
`define CMD_REG_WR   8'h08
`define CMD_REG_RD   8'h09

// ****************************************
// Fields, sizes and reset values
// ****************************************
`define BAUD_CHAR     8'h80
`define HALT_BIT      7
`define PROTECT_BIT   6
`define CTL_RESET     8'h00
`define RUN_MAX       16'hFFFF
`define PC_BLOCKED    16'hFFFF
`define TMR_W         14
`define BIT_W         10
`define BAUD_SHIFT    3
`define MIN_BIT_LEN   10'h004
`define FIFO_DEPTH    32

`endif

// ### logic/dbg_port_pkg.sv
package dbg_port_pkg;

   typedef enum logic [2:0] {
      RX_BAUD_WAIT,
      RX_BAUD_LOW,
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } rx_state_type;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_START,
      TX_DATA,
      TX_STOP
   } tx_state_type;

   typedef enum logic [3:0] {
      C_CMD,
      C_RSP,
      C_CTL,
      C_PC_HI,
      C_PC_LO,
      C_ADR_HI,
      C_ADR_LO,
      C_SIZE,
      C_WDATA,
      C_RDATA
   } cmd_state_type;

endpackage

// ### logic/byte_fifo.sv
`timescale 1ns/1ps
`include "dbg_port_defines.svh"

module byte_fifo import dbg_port_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0] count;
   } fifo_state_type;

   fifo_state_type s_q;
   fifo_state_type s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (s_q.count != (PW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data = mem[s_q.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.wr_ptr = (s_q.wr_ptr == (PW)'(DEPTH-1)) ? '0 : s_q.wr_ptr + 1'b1;
      end
      if (pop) begin
         s_d.rd_ptr = (s_q.rd_ptr == (PW)'(DEPTH-1)) ? '0 : s_q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         s_d.count = s_q.count + 1'b1;
      end else if (pop && !push) begin
         s_d.count = s_q.count - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Storage holds no reset
   always_ff @(posedge core_clk) begin
      if (clk_en && push) begin
         mem[s_q.wr_ptr] <= in_data;
      end
   end

endmodule // byte_fifo

// ### logic/onchip_debugger.sv
`timescale 1ns/1ps
`include "dbg_port_defines.svh"

module onchip_debugger import dbg_port_pkg::*; #(
   parameter logic [15:0] REVISION = 16'h0A5C, // Arbitrary value
   parameter logic [11:0] FLASH_CTL_LO = 12'hFF8,
   parameter logic [11:0] FLASH_CTL_HI = 12'hFFF,
   parameter logic [11:0] FLASH_CMD_ADDR = 12'hFF8,
   parameter logic [7:0] MASS_ERASE = 8'h63,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Debug pin
   input wire logic debug_serial_pin_in,
   output logic debug_serial_pin_out,
   output logic debug_serial_pin_oe,
   // Core status
   input wire logic read_protect_option,
   input wire logic watchpoint_hit,
   input wire logic stop_mode,
   output logic sys_reset_req,
   output logic debug_halt_flag,
   output logic [7:0] debugger_control_reg,
   // Program counter
   input wire logic [15:0] pc_value,
   output logic pc_wr_valid,
   output logic [15:0] pc_wr_data,
   // Register file
   output logic reg_wr_valid,
   output logic [11:0] reg_wr_addr,
   output logic [7:0] reg_wr_data,
   output logic [11:0] reg_rd_addr,
   input wire logic [7:0] reg_rd_data
);

   typedef struct packed {
      logic [2:0] sync;
      logic line;
      rx_state_type rx_st;
      logic [`TMR_W-1:0] rx_tmr;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_done;
      logic [`BIT_W-1:0] bit_len;
      tx_state_type tx_st;
      logic [`TMR_W-1:0] tx_tmr;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_out;
      cmd_state_type cmd_st;
      logic rd_cmd;
      logic [7:0] ctl;
      logic [15:0] run_cnt;
      logic [15:0] word;
      logic [1:0] rsp_cnt;
      logic [11:0] addr;
      logic [8:0] size;
      logic [15:0] pc_data;
      logic pc_wr;
      logic reg_wr;
      logic [11:0] wr_addr;
      logic [7:0] wr_data;
      logic sys_rst;
   } state_type;

   state_type s_q;
   state_type s_d;

   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [`TMR_W-1:0] period(input logic [`BIT_W-1:0] len);
      period = `TMR_W'(len) - 1'b1;
   endfunction

   function automatic logic [`TMR_W-1:0] half_period(input logic [`BIT_W-1:0] len);
      half_period = `TMR_W'(len >> 1);
   endfunction

   function automatic logic flash_ok(input logic [11:0] a, input logic [7:0] d);
      flash_ok = (a >= FLASH_CTL_LO) && (a <= FLASH_CTL_HI) && ((a != FLASH_CMD_ADDR) || (d == MASS_ERASE));
   endfunction

   // ****************************************
   // Response buffer
   // ****************************************
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rsp_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Half duplex: send only while the receiver rests on a high line
   assign fifo_out_ready = (s_q.tx_st == TX_IDLE) && (s_q.rx_st == RX_IDLE) && s_q.line;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic halt;
      logic prot;
      logic [7:0] b;
      s_d = s_q;
      halt = s_q.ctl[`HALT_BIT];
      prot = read_protect_option;
      b = s_q.rx_sh;
      fifo_in_valid = 1'b0;
      fifo_in_data = 8'h00;
      s_d.rx_done = 1'b0;
      s_d.pc_wr = 1'b0;
      s_d.reg_wr = 1'b0;

      // Pin synchroniser, change taken when the last two stages agree
      s_d.sync = {s_q.sync[1:0], debug_serial_pin_in};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.line = s_q.sync[2];
      end

      // Receiver and rate detector
      unique case (s_q.rx_st)
         RX_BAUD_WAIT: begin
            if (!s_q.line) begin
               s_d.rx_tmr = `TMR_W'(1);
               s_d.rx_st = RX_BAUD_LOW;
            end
         end
         RX_BAUD_LOW: begin
            if (s_q.rx_tmr != '1) begin
               s_d.rx_tmr = s_q.rx_tmr + 1'b1;
            end
            if (s_q.line) begin
               s_d.bit_len = `BIT_W'(s_q.rx_tmr >> `BAUD_SHIFT);
               if (s_d.bit_len < `MIN_BIT_LEN) begin
                  s_d.bit_len = `MIN_BIT_LEN;
               end
               s_d.rx_st = RX_IDLE;
            end
         end
         RX_IDLE: begin
            if (!s_q.line && (s_q.tx_st == TX_IDLE)) begin
               s_d.rx_tmr = half_period(s_q.bit_len);
               s_d.rx_st = RX_START;
            end
         end
         RX_START: begin
            if (s_q.rx_tmr != '0) begin
               s_d.rx_tmr = s_q.rx_tmr - 1'b1;
            end else if (!s_q.line) begin
               s_d.rx_tmr = period(s_q.bit_len);
               s_d.rx_bit = '0;
               s_d.rx_st = RX_DATA;
            end else begin
               s_d.rx_st = RX_IDLE;
            end
         end
         RX_DATA: begin
            if (s_q.rx_tmr != '0) begin
               s_d.rx_tmr = s_q.rx_tmr - 1'b1;
            end else begin
               s_d.rx_sh = {s_q.line, s_q.rx_sh[7:1]};
               s_d.rx_tmr = period(s_q.bit_len);
               s_d.rx_bit = s_q.rx_bit + 1'b1;
               if (s_q.rx_bit == 3'd7) begin
                  s_d.rx_st = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (s_q.rx_tmr != '0) begin
               s_d.rx_tmr = s_q.rx_tmr - 1'b1;
            end else begin
               s_d.rx_done = s_q.line;
               s_d.rx_st = RX_IDLE;
            end
         end
         default: begin
            s_d.rx_st = RX_BAUD_WAIT;
         end
      endcase

      // Transmitter
      unique case (s_q.tx_st)
         TX_IDLE: begin
            s_d.tx_out = 1'b1;
            if (fifo_out_valid && fifo_out_ready) begin
               s_d.tx_sh = fifo_out_data;
               s_d.tx_out = 1'b0;
               s_d.tx_tmr = period(s_q.bit_len);
               s_d.tx_st = TX_START;
            end
         end
         TX_START: begin
            if (s_q.tx_tmr != '0) begin
               s_d.tx_tmr = s_q.tx_tmr - 1'b1;
            end else begin
               s_d.tx_out = s_q.tx_sh[0];
               s_d.tx_sh = s_q.tx_sh >> 1;
               s_d.tx_bit = '0;
               s_d.tx_tmr = period(s_q.bit_len);
               s_d.tx_st = TX_DATA;
            end
         end
         TX_DATA: begin
            if (s_q.tx_tmr != '0) begin
               s_d.tx_tmr = s_q.tx_tmr - 1'b1;
            end else if (s_q.tx_bit == 3'd7) begin
               s_d.tx_out = 1'b1;
               s_d.tx_tmr = period(s_q.bit_len) + half_period(s_q.bit_len);
               s_d.tx_st = TX_STOP;
            end else begin
               s_d.tx_out = s_q.tx_sh[0];
               s_d.tx_sh = s_q.tx_sh >> 1;
               s_d.tx_bit = s_q.tx_bit + 1'b1;
               s_d.tx_tmr = period(s_q.bit_len);
            end
         end
         TX_STOP: begin
            if (s_q.tx_tmr != '0) begin
               s_d.tx_tmr = s_q.tx_tmr - 1'b1;
            end else begin
               s_d.tx_st = TX_IDLE;
            end
         end
      endcase

      // Command engine
      unique case (s_q.cmd_st)
         C_CMD: begin
            if (s_q.rx_done) begin
               s_d.rd_cmd = (b == `CMD_REG_RD);
               unique case (b)
                  `CMD_REV_RD: begin
                     s_d.word = REVISION;
                     s_d.rsp_cnt = 2'd2;
                     s_d.cmd_st = C_RSP;
                  end
                  `CMD_STAT_RD: begin
                     s_d.word = {halt, prot, 6'b00_0000, 8'h00};
                     s_d.rsp_cnt = 2'd1;
                     s_d.cmd_st = C_RSP;
                  end
                  `CMD_RUN_RD: begin
                     if (halt) begin
                        s_d.word = s_q.run_cnt;
                        s_d.rsp_cnt = 2'd2;
                        s_d.cmd_st = C_RSP;
                     end
                  end
                  `CMD_CTL_WR: begin
                     s_d.cmd_st = C_CTL;
                  end
                  `CMD_CTL_RD: begin
                     s_d.word = {s_q.ctl, 8'h00};
                     s_d.rsp_cnt = 2'd1;
                     s_d.cmd_st = C_RSP;
                  end
                  `CMD_PC_WR: begin
                     s_d.cmd_st = C_PC_HI;
                  end
                  `CMD_PC_RD: begin
                     s_d.word = (halt && !prot) ? pc_value : `PC_BLOCKED;
                     s_d.rsp_cnt = 2'd2;
                     s_d.cmd_st = C_RSP;
                  end
                  `CMD_REG_WR, `CMD_REG_RD: begin
                     s_d.cmd_st = C_ADR_HI;
                  end
                  default: begin
                     s_d.cmd_st = C_CMD;
                  end
               endcase
            end
         end
         C_RSP: begin
            fifo_in_valid = 1'b1;
            fifo_in_data = s_q.word[15:8];
            if (fifo_in_ready) begin
               s_d.word = {s_q.word[7:0], 8'h00};
               s_d.rsp_cnt = s_q.rsp_cnt - 1'b1;
               if (s_q.rsp_cnt == 2'd1) begin
                  s_d.cmd_st = C_CMD;
               end
            end
         end
         C_CTL: begin
            if (s_q.rx_done) begin
               s_d.ctl = b;
               if (prot) begin
                  s_d.ctl[`HALT_BIT] = halt | b[`HALT_BIT];
               end
               s_d.cmd_st = C_CMD;
            end
         end
         C_PC_HI: begin
            if (s_q.rx_done) begin
               s_d.pc_data[15:8] = b;
               s_d.cmd_st = C_PC_LO;
            end
         end
         C_PC_LO: begin
            if (s_q.rx_done) begin
               s_d.pc_data[7:0] = b;
               s_d.pc_wr = halt && !prot;
               s_d.cmd_st = C_CMD;
            end
         end
         C_ADR_HI: begin
            if (s_q.rx_done) begin
               s_d.addr[11:8] = b[3:0];
               s_d.cmd_st = C_ADR_LO;
            end
         end
         C_ADR_LO: begin
            if (s_q.rx_done) begin
               s_d.addr[7:0] = b;
               s_d.cmd_st = C_SIZE;
            end
         end
         C_SIZE: begin
            if (s_q.rx_done) begin
               s_d.size = (b == 8'h00) ? 9'h100 : {1'b0, b};
               if (!s_q.rd_cmd) begin
                  s_d.cmd_st = C_WDATA;
               end else if (halt && !prot) begin
                  s_d.cmd_st = C_RDATA;
               end else begin
                  s_d.cmd_st = C_CMD;
               end
            end
         end
         C_WDATA: begin
            if (s_q.rx_done) begin
               s_d.reg_wr = halt && (!prot || flash_ok(s_q.addr, b));
               s_d.wr_addr = s_q.addr;
               s_d.wr_data = b;
               s_d.addr = s_q.addr + 1'b1;
               s_d.size = s_q.size - 1'b1;
               if (s_q.size == 9'h001) begin
                  s_d.cmd_st = C_CMD;
               end
            end
         end
         C_RDATA: begin
            fifo_in_valid = 1'b1;
            fifo_in_data = reg_rd_data;
            if (fifo_in_ready) begin
               s_d.addr = s_q.addr + 1'b1;
               s_d.size = s_q.size - 1'b1;
               if (s_q.size == 9'h001) begin
                  s_d.cmd_st = C_CMD;
               end
            end
         end
         default: begin
            s_d.cmd_st = C_CMD;
         end
      endcase

      // Watchpoint entry wins over a clear in the same cycle
      if (watchpoint_hit) begin
         s_d.ctl[`HALT_BIT] = 1'b1;
      end

      // Runtime counter
      if (halt && !s_d.ctl[`HALT_BIT]) begin
         s_d.run_cnt = '0;
      end else if (!halt && (s_q.run_cnt != `RUN_MAX)) begin
         s_d.run_cnt = s_q.run_cnt + 1'b1;
      end

      s_d.sys_rst = stop_mode && !s_q.line;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{sync: 3'b111, line: 1'b1, rx_st: RX_BAUD_WAIT, rx_tmr: '0, rx_bit: '0, rx_sh: '0,
                  rx_done: 1'b0, bit_len: `MIN_BIT_LEN, tx_st: TX_IDLE, tx_tmr: '0, tx_bit: '0,
                  tx_sh: '0, tx_out: 1'b1, cmd_st: C_CMD, rd_cmd: 1'b0, ctl: `CTL_RESET,
                  run_cnt: '0, word: '0, rsp_cnt: '0, addr: '0, size: '0, pc_data: '0,
                  pc_wr: 1'b0, reg_wr: 1'b0, wr_addr: '0, wr_data: '0, sys_rst: 1'b0};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign debug_serial_pin_out = s_q.tx_out;
   assign debug_serial_pin_oe = (s_q.tx_st != TX_IDLE);
   assign sys_reset_req = s_q.sys_rst;
   assign debug_halt_flag = s_q.ctl[`HALT_BIT];
   assign debugger_control_reg = s_q.ctl;
   assign pc_wr_valid = s_q.pc_wr;
   assign pc_wr_data = s_q.pc_data;
   assign reg_wr_valid = s_q.reg_wr;
   assign reg_wr_addr = s_q.wr_addr;
   assign reg_wr_data = s_q.wr_data;
   assign reg_rd_addr = s_q.addr;

endmodule // onchip_debugger

// ### test/dbg_port_chk.sv
`timescale 1ns/1ps

module dbg_port_chk #(
   parameter logic [11:0] FLASH_CTL_LO = 12'hFF8,
   parameter logic [11:0] FLASH_CTL_HI = 12'hFFF,
   parameter logic [11:0] FLASH_CMD_ADDR = 12'hFF8,
   parameter logic [7:0] MASS_ERASE = 8'h63
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Pin and core status
   input wire logic debug_serial_pin_in,
   input wire logic debug_serial_pin_out,
   input wire logic debug_serial_pin_oe,
   input wire logic read_protect_option,
   input wire logic watchpoint_hit,
   input wire logic stop_mode,
   input wire logic sys_reset_req,
   input wire logic debug_halt_flag,
   input wire logic [7:0] debugger_control_reg,
   // Write strobes
   input wire logic pc_wr_valid,
   input wire logic reg_wr_valid,
   input wire logic [11:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence pin_held_low;
      (stop_mode && !debug_serial_pin_in) [*6];
   endsequence
   sequence locked_halt;
      read_protect_option && debug_halt_flag ##1 read_protect_option;
   endsequence

   idle_pin_high_a: assert property (!debug_serial_pin_oe |-> debug_serial_pin_out)
      else $error("released pin not resting high");
   watch_sets_a: assert property (watchpoint_hit && clk_en |=> debug_halt_flag)
      else $error("watchpoint did not halt");
   protect_lock_a: assert property (locked_halt |-> debug_halt_flag)
      else $error("halt cleared under protection");
   pc_guard_a: assert property (pc_wr_valid |-> debug_halt_flag && !read_protect_option)
      else $error("pc write while not allowed");
   pc_single_a: assert property (pc_wr_valid |=> !pc_wr_valid)
      else $error("pc write pulse too long");
   reg_guard_a: assert property (reg_wr_valid |-> debug_halt_flag)
      else $error("register write outside debug");
   reg_protect_a: assert property (reg_wr_valid && read_protect_option |->
      reg_wr_addr >= FLASH_CTL_LO && reg_wr_addr <= FLASH_CTL_HI &&
      (reg_wr_addr != FLASH_CMD_ADDR || reg_wr_data == MASS_ERASE))
      else $error("protected register write passed");
   stop_reset_a: assert property (pin_held_low |=> sys_reset_req)
      else $error("no reset request in stop mode");
   start_bit_a: assert property ($rose(debug_serial_pin_oe) |-> ##[0:1] !debug_serial_pin_out)
      else $error("reply does not open with a start bit");
endmodule // dbg_port_chk

bind onchip_debugger dbg_port_chk #(.FLASH_CTL_LO(FLASH_CTL_LO), .FLASH_CTL_HI(FLASH_CTL_HI),
   .FLASH_CMD_ADDR(FLASH_CMD_ADDR), .MASS_ERASE(MASS_ERASE)) chk_u (.core_clk(core_clk), .rst_b(rst_b),
   .clk_en(clk_en), .debug_serial_pin_in(debug_serial_pin_in), .debug_serial_pin_out(debug_serial_pin_out),
   .debug_serial_pin_oe(debug_serial_pin_oe), .read_protect_option(read_protect_option),
   .watchpoint_hit(watchpoint_hit), .stop_mode(stop_mode), .sys_reset_req(sys_reset_req),
   .debug_halt_flag(debug_halt_flag), .debugger_control_reg(debugger_control_reg), .pc_wr_valid(pc_wr_valid),
   .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));

// ### test/host_debug_model.sv
`timescale 1ns/1ps

module host_debug_model #(
   parameter int BIT = 16
) (
   // Clock and wire
   input wire logic core_clk,
   input wire logic line,
   output logic host_low
);
   initial host_low = 1'b0;

   // Idle of 1.5 bits before each start keeps the stop length
   task automatic send(input logic [7:0] b);
      int i;
      host_low = 1'b0;
      repeat (BIT + BIT / 2) @(negedge core_clk);
      host_low = 1'b1;
      repeat (BIT) @(negedge core_clk);
      for (i = 0; i < 8; i++) begin
         host_low = !b[i];
         repeat (BIT) @(negedge core_clk);
      end
      host_low = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask

   task automatic recv(output logic [7:0] b, output bit ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      for (n = 0; n < 4000 && line !== 1'b0; n++) @(negedge core_clk);
      if (line !== 1'b0) return;
      repeat (BIT / 2) @(negedge core_clk);
      ok = (line === 1'b0);
      for (n = 0; n < 8; n++) begin
         repeat (BIT) @(negedge core_clk);
         b[n] = line;
      end
      repeat (BIT) @(negedge core_clk);
      ok = ok && (line === 1'b1);
   endtask
endmodule // host_debug_model

// ### test/onchip_debug_serial_port_test.sv
`timescale 1ns/1ps

module onchip_debug_serial_port_test import dbg_port_pkg::*;;
   localparam logic [15:0] REV = 16'h5E21; // Arbitrary value
   logic core_clk, rst_b, clk_en, prot, wp, stop_m, host_low, line, pin_out, oe, sysreq, halt, pcv, rwv;
   logic [7:0] ctl, rwd, rrd, mask;
   logic [11:0] rwa, rra;
   logic [15:0] pc_val, pcd;
   logic [7:0] rxq[$];
   logic [31:0] wq[$], exp_wq[$], pcq[$];
   int bad_count, total_checks, seed;
   bit exp_halt;

   assign line = (oe ? pin_out : 1'b1) & !host_low;
   assign rrd = rra[7:0] ^ mask;
   always #2 core_clk = !core_clk;
   always @(posedge core_clk) begin
      if (rwv === 1'b1) wq.push_back({rwa, rwd});
      if (pcv === 1'b1) pcq.push_back(pcd);
   end

   onchip_debugger #(.REVISION(REV)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .debug_serial_pin_in(line), .debug_serial_pin_out(pin_out), .debug_serial_pin_oe(oe),
      .read_protect_option(prot), .watchpoint_hit(wp), .stop_mode(stop_m), .sys_reset_req(sysreq),
      .debug_halt_flag(halt), .debugger_control_reg(ctl), .pc_value(pc_val), .pc_wr_valid(pcv),
      .pc_wr_data(pcd), .reg_wr_valid(rwv), .reg_wr_addr(rwa), .reg_wr_data(rwd), .reg_rd_addr(rra),
      .reg_rd_data(rrd));
   host_debug_model host_u (.core_clk(core_clk), .line(line), .host_low(host_low));

   task stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task cmd(input logic [7:0] b[$], input int n);
      logic [7:0] r;
      bit ok;
      rxq = {};
      foreach (b[i]) host_u.send(b[i]);
      repeat (n) begin
         host_u.recv(r, ok);
         if (!ok) begin
            bad_count++;
            $display("MISMATCH at %0t: reply missing", $time);
            stop_test();
         end
         rxq.push_back(r);
      end
   endtask

   task regwr(input logic [11:0] a, input int n, input logic [7:0] ev);
      logic [7:0] d;
      cmd({8'h08, 8'(a[11:8]), a[7:0], n[7:0]}, 0);
      repeat (n) begin
         d = (a == 12'hFF8) ? ev : 8'($urandom);
         host_u.send(d);
         if (exp_halt && (!prot || (a >= 12'hFF8 && (a != 12'hFF8 || d == 8'h63)))) exp_wq.push_back({a, d});
         a++;
      end
      repeat (16) @(negedge core_clk);
      chk(wq.size(), exp_wq.size());
      while (wq.size() > 0 && exp_wq.size() > 0) chk(wq.pop_front(), exp_wq.pop_front());
   endtask

   task pulse_wp();
      wp = 1'b1;
      @(negedge core_clk);
      wp = 1'b0;
      exp_halt = 1'b1;
      @(negedge core_clk);
   endtask

   initial begin
      logic [11:0] a;
      logic [15:0] pw, r1;
      core_clk = 1'b0; rst_b = 1'b0; clk_en = 1'b1; prot = 1'b0; wp = 1'b0; stop_m = 1'b0;
      seed = $urandom(47);
      pc_val = 16'($urandom);
      mask = 8'($urandom);
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      // Rate character, then commands outside debug
      host_u.send(8'h80);
      cmd({8'h01}, 0);
      cmd({8'h03}, 0);
      repeat (40) @(negedge core_clk);
      chk(oe, 1'b0);
      cmd({8'h02}, 1); chk(rxq[0], 8'h00);
      cmd({8'h00}, 2); chk({rxq[0], rxq[1]}, REV);
      cmd({8'h07}, 2); chk({rxq[0], rxq[1]}, 16'hFFFF);
      cmd({8'h05}, 1); chk(rxq[0], 8'h00);
      cmd({8'h06, 8'h12, 8'h34}, 0); repeat (16) @(negedge core_clk); chk(pcq.size(), 0);
      regwr(12'h123, 2, 8'h00);
      $display("idle test done");
      // Debug entry, program counter and register file
      pulse_wp(); chk(halt, 1'b1);
      cmd({8'h05}, 1); chk(rxq[0], 8'h80);
      cmd({8'h02}, 1); chk(rxq[0], 8'h80);
      cmd({8'h07}, 2); chk({rxq[0], rxq[1]}, pc_val);
      pw = 16'($urandom);
      cmd({8'h06, pw[15:8], pw[7:0]}, 0); repeat (16) @(negedge core_clk);
      chk(pcq.size(), 1); chk(pcq[0], pw);
      a = 12'($urandom);
      regwr(a, 3, 8'h00);
      cmd({8'h09, 8'(a[11:8]), a[7:0], 8'h02}, 2);
      chk(rxq[0], a[7:0] ^ mask); chk(rxq[1], 8'(a + 12'h001) ^ mask);
      $display("debug test done");
      // Runtime counter
      cmd({8'h04, 8'h00}, 0); exp_halt = 1'b0;
      repeat (100) @(negedge core_clk);
      // Frozen cycles must not count
      clk_en = 1'b0;
      repeat (50) @(negedge core_clk);
      clk_en = 1'b1;
      repeat (50) @(negedge core_clk);
      pulse_wp();
      cmd({8'h03}, 2); r1 = {rxq[0], rxq[1]};
      chk(r1 >= 16'd130 && r1 <= 16'd160, 1);
      cmd({8'h03}, 2); chk({rxq[0], rxq[1]}, r1);
      cmd({8'h04, 8'h00}, 0); exp_halt = 1'b0;
      repeat (66000) @(negedge core_clk);
      pulse_wp();
      cmd({8'h03}, 2); chk({rxq[0], rxq[1]}, 16'hFFFF);
      $display("counter test done");
      // Read protection
      prot = 1'b1;
      cmd({8'h04, 8'h00}, 0);
      cmd({8'h02}, 1); chk(rxq[0], 8'hC0);
      cmd({8'h07}, 2); chk({rxq[0], rxq[1]}, 16'hFFFF);
      cmd({8'h06, 8'h55, 8'hAA}, 0); repeat (16) @(negedge core_clk); chk(pcq.size(), 1);
      regwr(12'hFF7, 4, 8'h63);
      regwr(12'hFF8, 1, 8'h12);
      cmd({8'h09, 8'h00, 8'h10, 8'h01}, 0);
      repeat (40) @(negedge core_clk);
      chk(oe, 1'b0);
      $display("protect test done");
      // Pin low in stop mode, then a device reset
      stop_m = 1'b1; host_u.host_low = 1'b1;
      repeat (10) @(negedge core_clk);
      chk(sysreq, 1'b1);
      host_u.host_low = 1'b0; stop_m = 1'b0; rst_b = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      chk(ctl, 8'h00);
      $display("reset test done");
      stop_test();
   end
endmodule // onchip_debug_serial_port_test
